// [ccp_unit.sv]
// Purpose: one capture/compare/pwm channel with wishbone registers
// Assumes: timebase16 count and its increment pulse come from mclk logic
// Notes:   pwm timebase is kept here; pin events are synchronised
//
// Overview of operation
// - capture trigger picked from eight sources by 3-bit select
// - port write to an output pin may itself cause a capture
// - prescaler cleared when disabled, not capturing, or in reset
// - prescaler change does not clear counter; clear control first
// - in sleep, capture works only with externally clocked timebase
// - compare mode checks 16-bit value against timebase count
// - match sets, clears or toggles output and sets event flag
// - every compare mode flags a match and may trigger adc
// - adc trigger on match while flag set and module selected
// - value change before timebase reset cancels that reset
// - control register clear forces compare output latch low
// - module output also offered to other peripherals
// - flagged match with interrupt enabled wakes the device
// - pwm output with up to ten bits of resolution
// - capture on falling, rising, every 4th or 16th rising edge
// - capture copies timebase to value pair and sets flag
// - at period match timer clears, pin sets (stays low if duty is zero), duty loads
// - pin clears when 10-bit time base equals buffered duty
//
// Our own choices: the register offsets and the Wishbone slave port.
`timescale 1ns/100ps
`default_nettype none
`include "ccp_map.svh"
module ccp_unit (
  input  wire logic        mclk,
  input  wire logic        rst,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [5:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output var  logic [31:0] wb_dat_o,
  output var  logic        wb_ack_o,
  input  wire logic        routed_pin_input,
  input  wire logic        comparator_one_synced,
  input  wire logic        comparator_two_synced,
  input  wire logic        pin_change_event,
  input  wire logic        logic_cell_one_output,
  input  wire logic        logic_cell_two_output,
  input  wire logic        logic_cell_three_output,
  input  wire logic        logic_cell_four_output,
  input  wire logic        port_write,
  input  wire logic [15:0] timebase16_count,
  input  wire logic        timebase16_tick,
  output var  logic        timebase16_reset,
  output var  logic        pin_out,
  output var  logic        module_out,
  output var  logic        adc_trigger,
  output var  logic        wake_request
);
  typedef struct packed {
    logic [7:0]              ctrl;
    logic [2:0]              src;
    logic [15:0]             value;
    logic                    flag;
    logic                    ien;
    logic [7:0]              period;
    logic [2:0]              pwmctl;
    logic                    adcsel;
    logic                    pwm_flag;
    logic [3:0]              psc;
    logic                    trig_d;
    logic                    out;
    logic [7:0]              tmr;
    logic [1:0]              sub;
    logic [9:0]              duty;
    logic                    cmp_hit;
    logic                    rst_pend;
    logic [15:0]             rst_val;
    logic                    adc;
    logic                    tb_rst;
    logic                    wake;
    logic                    ack;
    logic [31:0]             rdat;
  } ccp_state_t;

  ccp_state_t s_r, s_nxt;
  logic [7:0] pin_sync;
  logic       trig;
  logic       rise, fall, cap_ev, match;
  logic       en;
  logic [9:0] duty_src;
  logic       cmp_ev, pwm_run, pwm_wrap;
  ccp_pkg::ccp_mode_t mode;
  logic       wr, rd;

  // pin side inputs cross into mclk domain
  ccp_sync #(.W(8)) u_sync (
    .mclk (mclk),
    .rst  (rst),
    .d    ({logic_cell_four_output, logic_cell_three_output,
            logic_cell_two_output, logic_cell_one_output,
            pin_change_event, comparator_two_synced,
            comparator_one_synced, routed_pin_input | port_write}),
    .q    (pin_sync)
  );

  // decode of control and source
  always_comb begin
    mode   = ccp_pkg::ccp_mode_t'(s_r.ctrl[3:0]);
    en     = s_r.ctrl[`CCP_CTRL_EN];
    trig   = pin_sync[s_r.src];
    rise   = trig & ~s_r.trig_d;
    fall   = ~trig & s_r.trig_d;
    match  = (timebase16_count == s_r.value);
    duty_src = s_r.ctrl[`CCP_CTRL_FMT] ? s_r.value[15:6] : s_r.value[9:0];
    wr     = wb_cyc_i & wb_stb_i & wb_we_i & ~s_r.ack & wb_sel_i[0];
    rd     = wb_cyc_i & wb_stb_i & ~s_r.ack;
    cap_ev = 1'b0;
    case (mode)
      ccp_pkg::CCP_M_CAP_ANY: cap_ev = rise | fall;
      ccp_pkg::CCP_M_CAP_F:   cap_ev = fall;
      ccp_pkg::CCP_M_CAP_R:   cap_ev = rise;
      ccp_pkg::CCP_M_CAP_R4:  cap_ev = rise && s_r.psc == `CCP_PSC_FOUR;
      ccp_pkg::CCP_M_CAP_R16: cap_ev = rise && s_r.psc == `CCP_PSC_SIXTEEN;
      default:                cap_ev = 1'b0;
    endcase
    cap_ev = cap_ev & en;
    cmp_ev = en && match && !s_r.cmp_hit &&
             mode inside {ccp_pkg::CCP_M_CMP_TR, ccp_pkg::CCP_M_CMP_TG,
                          [ccp_pkg::CCP_M_CMP_SET:ccp_pkg::CCP_M_CMP_PLR]};
    pwm_run  = en && s_r.pwmctl[`CCP_PWMCTL_ON] && mode == ccp_pkg::CCP_M_PWM;
    pwm_wrap = pwm_run && s_r.sub == 2'h3 && s_r.tmr == s_r.period;
  end

  // next state of the whole channel
  always_comb begin
    s_nxt        = s_r;
    s_nxt.trig_d = trig;
    s_nxt.adc    = 1'b0;
    s_nxt.tb_rst = 1'b0;
    s_nxt.ack    = 1'b0;
    s_nxt.wake   = s_r.flag & s_r.ien;
    // prescaler counts rising edges only while capturing
    if (!en || !(mode inside {[ccp_pkg::CCP_M_CAP_ANY:ccp_pkg::CCP_M_CAP_R16]}))
      s_nxt.psc = 4'h0;
    else if (rise && (mode == ccp_pkg::CCP_M_CAP_R4 ||
                      mode == ccp_pkg::CCP_M_CAP_R16)) begin
      if (cap_ev)
        s_nxt.psc = 4'h0;
      else
        s_nxt.psc = s_r.psc + 4'h1;
    end
    // capture copies timebase, later events overwrite
    if (cap_ev) begin
      s_nxt.value = timebase16_count;
      s_nxt.flag  = 1'b1;
    end
    // compare acts once per timebase step
    s_nxt.cmp_hit = s_r.cmp_hit;
    if (timebase16_tick)
      s_nxt.cmp_hit = 1'b0;
    if (cmp_ev) begin
      s_nxt.cmp_hit = 1'b1;
      s_nxt.flag    = 1'b1;
      s_nxt.adc     = s_r.adcsel;
      case (mode)
        ccp_pkg::CCP_M_CMP_TG,
        ccp_pkg::CCP_M_CMP_TR:  s_nxt.out = ~s_r.out;
        ccp_pkg::CCP_M_CMP_SET: s_nxt.out = 1'b1;
        ccp_pkg::CCP_M_CMP_CLR: s_nxt.out = 1'b0;
        default:                s_nxt.out = 1'b1;       // pulse high
      endcase
      if (mode == ccp_pkg::CCP_M_CMP_TR || mode == ccp_pkg::CCP_M_CMP_PLR) begin
        s_nxt.rst_pend = 1'b1;
        s_nxt.rst_val  = s_r.value;
      end
    end else if (mode inside {ccp_pkg::CCP_M_CMP_PL, ccp_pkg::CCP_M_CMP_PLR}
                 && s_r.out && !match)
      s_nxt.out = 1'b0;                                 // end of pulse
    // timebase reset one edge later, dropped if value moved
    if (s_r.rst_pend) begin
      s_nxt.rst_pend = 1'b0;
      s_nxt.tb_rst   = (s_r.value == s_r.rst_val);
    end
    // pwm timebase with period and duty buffer
    if (pwm_run) begin
      s_nxt.sub = s_r.sub + 2'h1;
      if (pwm_wrap) begin
        s_nxt.tmr      = 8'h00;
        s_nxt.duty     = duty_src;
        s_nxt.out      = (duty_src != 10'h000);
        s_nxt.pwm_flag = 1'b1;
      end else if (s_r.sub == 2'h3)
        s_nxt.tmr = s_r.tmr + 8'h01;
      // clear as the next base value reaches the buffered duty
      if ({s_nxt.tmr, s_nxt.sub} == s_nxt.duty)
        s_nxt.out = 1'b0;
    end
    // bus writes; hardware sets of flag and pwm_flag win over software clears
    if (wr) begin
      case (wb_adr_i)
        `CCP_OFS_CTRL: begin
          s_nxt.ctrl = wb_dat_i[7:0] & 8'h9f;
          if (wb_dat_i[7:0] == `CCP_CTRL_RST)
            s_nxt.out = 1'b0;
        end
        `CCP_OFS_SRC:    s_nxt.src = wb_dat_i[2:0];
        `CCP_OFS_VALUE:  if (!cap_ev) s_nxt.value = wb_dat_i[15:0];
        `CCP_OFS_STATUS: begin
          if (wb_dat_i[0] && !cap_ev && !cmp_ev)
            s_nxt.flag = 1'b0;
          if (wb_dat_i[1] && !pwm_wrap)
            s_nxt.pwm_flag = 1'b0;
        end
        `CCP_OFS_IEN:    s_nxt.ien    = wb_dat_i[0];
        `CCP_OFS_PERIOD: s_nxt.period = wb_dat_i[7:0];
        `CCP_OFS_PWMCTL: s_nxt.pwmctl = wb_dat_i[2:0];
        `CCP_OFS_ADCSEL: s_nxt.adcsel = wb_dat_i[0];
        default: ;
      endcase
    end
    // read data and single cycle ack
    if (rd) begin
      s_nxt.ack = 1'b1;
      case (wb_adr_i)
        `CCP_OFS_CTRL:   s_nxt.rdat = {24'h0, s_r.ctrl[7:6], s_r.out,
                                       s_r.ctrl[4:0]};
        `CCP_OFS_SRC:    s_nxt.rdat = {29'h0, s_r.src};
        `CCP_OFS_VALUE:  s_nxt.rdat = {16'h0, s_r.value};
        `CCP_OFS_STATUS: s_nxt.rdat = {30'h0, s_r.pwm_flag, s_r.flag};
        `CCP_OFS_IEN:    s_nxt.rdat = {31'h0, s_r.ien};
        `CCP_OFS_PERIOD: s_nxt.rdat = {24'h0, s_r.period};
        `CCP_OFS_PWMCTL: s_nxt.rdat = {29'h0, s_r.pwmctl};
        `CCP_OFS_ADCSEL: s_nxt.rdat = {31'h0, s_r.adcsel};
        default:         s_nxt.rdat = 32'h0;
      endcase
    end
  end

  // the one state register
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      s_r        <= '0;
      s_r.period <= `CCP_PERIOD_RST;
    end else
      s_r <= s_nxt;
  end

  // outputs straight from state flops
  always_comb begin
    wb_dat_o         = s_r.rdat;
    wb_ack_o         = s_r.ack;
    pin_out          = s_r.out;
    module_out       = s_r.out;
    adc_trigger      = s_r.adc;
    timebase16_reset = s_r.tb_rst;
    wake_request     = s_r.wake;
  end

  property p_cap_copy;
    @(posedge mclk) disable iff (rst)
      cap_ev |=> s_r.flag && s_r.value == $past(timebase16_count);
  endproperty
  a_cap_copy: assert property (p_cap_copy) else $error("capture lost");

  property p_psc_clear;
    @(posedge mclk) disable iff (rst)
      !en |=> s_r.psc == 4'h0;
  endproperty
  a_psc_clear: assert property (p_psc_clear) else $error("psc kept");

  property p_once;
    @(posedge mclk) disable iff (rst)
      s_r.cmp_hit && !timebase16_tick |=> !adc_trigger;
  endproperty
  a_once: assert property (p_once) else $error("double match");

  property p_adc_sel;
    @(posedge mclk) disable iff (rst)
      adc_trigger |-> s_r.adcsel && s_r.flag;
  endproperty
  a_adc_sel: assert property (p_adc_sel) else $error("bad adc");

  property p_tbrst;
    @(posedge mclk) disable iff (rst)
      timebase16_reset |-> $past(s_r.rst_pend) &&
                           $past(s_r.value) == $past(s_r.rst_val);
  endproperty
  a_tbrst: assert property (p_tbrst) else $error("bad tb reset");

  property p_set;
    @(posedge mclk) disable iff (rst)
      en && match && !s_r.cmp_hit && mode == ccp_pkg::CCP_M_CMP_SET && !wr
        |=> pin_out && s_r.flag;
  endproperty
  a_set: assert property (p_set) else $error("set mode");

  property p_clr;
    @(posedge mclk) disable iff (rst)
      wr && wb_adr_i == `CCP_OFS_CTRL && wb_dat_i[7:0] == 8'h00 |=> !pin_out;
  endproperty
  a_clr: assert property (p_clr) else $error("latch not low");

  property p_wake;
    @(posedge mclk) disable iff (rst)
      s_r.flag && s_r.ien |=> wake_request;
  endproperty
  a_wake: assert property (p_wake) else $error("no wake");

  property p_period;
    @(posedge mclk) disable iff (rst)
      en && mode == ccp_pkg::CCP_M_PWM && s_r.pwmctl[`CCP_PWMCTL_ON]
        && s_r.sub == 2'h3 && s_r.tmr == s_r.period && !wr |=> s_r.tmr == 8'h00;
  endproperty
  a_period: assert property (p_period) else $error("no wrap");
endmodule : ccp_unit
`default_nettype wire

// [ccp_map.svh]
// Purpose: offsets, field positions, reset values and counts for the ccp unit
// Assumes: wishbone word addressing, byte addresses are multiples of four
// Notes:   definitions only
`ifndef CCP_MAP_SVH
`define CCP_MAP_SVH
`define CCP_OFS_CTRL      6'h00
`define CCP_OFS_SRC       6'h04
`define CCP_OFS_VALUE     6'h08
`define CCP_OFS_STATUS    6'h0c
`define CCP_OFS_IEN       6'h10
`define CCP_OFS_PERIOD    6'h14
`define CCP_OFS_PWMCTL    6'h18
`define CCP_OFS_ADCSEL    6'h1c
`define CCP_CTRL_EN       7
`define CCP_CTRL_OUT      5
`define CCP_CTRL_FMT      4
`define CCP_PWMCTL_ON     2
`define CCP_CTRL_RST      8'h00
`define CCP_PERIOD_RST    8'hff
`define CCP_PSC_FOUR      4'h3
`define CCP_PSC_SIXTEEN   4'hf
`endif

// [ccp_pkg.sv]
// Purpose: types shared by the ccp unit
// Assumes: nothing
// Notes:   mode codes follow the control field encoding
package ccp_pkg;
  typedef enum logic [3:0] {
    CCP_M_OFF     = 4'h0,
    CCP_M_CMP_TR  = 4'h1,
    CCP_M_CMP_TG  = 4'h2,
    CCP_M_CAP_ANY = 4'h3,
    CCP_M_CAP_F   = 4'h4,
    CCP_M_CAP_R   = 4'h5,
    CCP_M_CAP_R4  = 4'h6,
    CCP_M_CAP_R16 = 4'h7,
    CCP_M_CMP_SET = 4'h8,
    CCP_M_CMP_CLR = 4'h9,
    CCP_M_CMP_PL  = 4'ha,
    CCP_M_CMP_PLR = 4'hb,
    CCP_M_PWM     = 4'hf
  } ccp_mode_t;
  typedef enum {CCP_BUS_IDLE, CCP_BUS_ACK} ccp_bus_st_t;
endpackage : ccp_pkg

// [ccp_sync.sv]
// Purpose: two flop synchroniser for pin level inputs
// Assumes: inputs are asynchronous to mclk
// Notes:   first stage feeds only the second
`timescale 1ns/100ps
`default_nettype none
module ccp_sync #(
  parameter int W = 1
) (
  input  wire logic         mclk,
  input  wire logic         rst,
  input  wire logic [W-1:0] d,
  output var  logic [W-1:0] q
);
  logic [W-1:0] meta_r;
  // two stage capture
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      meta_r <= '0;
      q      <= '0;
    end else begin
      meta_r <= d;
      q      <= meta_r;
    end
  end
endmodule : ccp_sync
`default_nettype wire

// [ccp_far_model.sv]
// Purpose: far side model, a 16-bit timebase run from mclk
// Assumes: steps once every four mclk cycles while run is high
// Notes:   obeys the channel's reset request; load sets the count
`timescale 1ns/100ps
`default_nettype none
module ccp_far_model (
  input  wire logic        mclk,
  input  wire logic        rst,
  input  wire logic        run,
  input  wire logic        load,
  input  wire logic [15:0] load_val,
  input  wire logic        timebase16_reset,
  output var  logic [15:0] timebase16_count,
  output var  logic        timebase16_tick
);
  logic [1:0] div_r;
  // synchronous counter on a divided mclk, holds its value when stopped
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      div_r            <= 2'h0;
      timebase16_count <= 16'h0000;
      timebase16_tick  <= 1'b0;
    end else begin
      timebase16_tick <= 1'b0;
      if (load) begin
        timebase16_count <= load_val;
      end else if (timebase16_reset) begin
        timebase16_count <= 16'h0000;
      end else if (run) begin
        div_r <= div_r + 2'h1;
        if (div_r == 2'h3) begin
          timebase16_count <= timebase16_count + 16'h0001;
          timebase16_tick  <= 1'b1;
        end
      end
    end
  end
endmodule : ccp_far_model
`default_nettype wire

// [testbench.sv]
// Purpose: self checking bench for the ccp channel
// Assumes: read answers are queued and matched by a monitor
// Notes:   timebase comes from the far side model
`timescale 1ns/100ps
`default_nettype none
`include "ccp_map.svh"
module testbench;
  logic        mclk = 1'b0;
  logic        rst = 1'b1;
  logic        wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [5:0]  wb_adr_i = 6'h00;
  logic [3:0]  wb_sel_i = 4'hf;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o;
  logic        wb_ack_o, port_write = 1'b0, run = 1'b0, load = 1'b0, g;
  logic [7:0]  srcs = 8'h00;
  logic [15:0] load_val = 16'h0000, timebase16_count, v;
  logic        timebase16_tick, timebase16_reset, pin_out, module_out;
  logic        adc_trigger, wake_request;
  logic [63:0] exp_q[$];
  logic [63:0] nt;
  int          num_errors = 0, n_checks = 0, seed = 32'h36b0, i, nh, nl;

  // free running clock
  always #2.5 mclk = ~mclk;

  ccp_unit u_ccp_unit (
    .mclk(mclk), .rst(rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .routed_pin_input(srcs[0]), .comparator_one_synced(srcs[1]),
    .comparator_two_synced(srcs[2]), .pin_change_event(srcs[3]),
    .logic_cell_one_output(srcs[4]), .logic_cell_two_output(srcs[5]),
    .logic_cell_three_output(srcs[6]), .logic_cell_four_output(srcs[7]),
    .port_write(port_write), .timebase16_count(timebase16_count),
    .timebase16_tick(timebase16_tick), .timebase16_reset(timebase16_reset),
    .pin_out(pin_out), .module_out(module_out), .adc_trigger(adc_trigger),
    .wake_request(wake_request)
  );
  ccp_far_model u_ccp_far_model (
    .mclk(mclk), .rst(rst), .run(run), .load(load), .load_val(load_val),
    .timebase16_reset(timebase16_reset), .timebase16_count(timebase16_count),
    .timebase16_tick(timebase16_tick)
  );

  task automatic stop_test;
    $display("checks %0d mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : stop_test

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // one classic cycle, held until ack is sampled high
  task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
    int n;
    n = 0;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do begin
      @(posedge mclk);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 40);
    if (n >= 40) chk(32'(wb_ack_o), 32'h1);
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i  <= 1'b0;
    @(posedge mclk);
  endtask : bus

  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask : wr

  task automatic rd(input logic [5:0] a, input logic [31:0] e,
                    input logic [31:0] m);
    exp_q.push_back({m, e & m});
    bus(1'b0, a, 32'h0);
  endtask : rd

  // read answers against the oldest note
  always @(posedge mclk) begin
    if (wb_ack_o === 1'b1 && wb_we_i === 1'b0) begin
      nt = exp_q.pop_front();
      chk(wb_dat_o & nt[63:32], nt[31:0]);
    end
  end

  // wait for an output level, leaving the last sample in g
  task automatic wait_out(input int w, input logic val, input int n);
    for (int k = 0; k < n; k++) begin
      @(posedge mclk);
      g = (w == 0) ? pin_out : (w == 1) ? adc_trigger :
          (w == 2) ? wake_request : timebase16_reset;
      if (g === val) break;
    end
  endtask : wait_out

  // count the samples for which pin_out keeps one level
  task automatic hold(input logic val, output int n);
    n = 1;
    for (int k = 0; k < 200; k++) begin
      @(posedge mclk);
      if (pin_out !== val) break;
      n++;
    end
  endtask : hold

  task automatic setcnt(input logic [15:0] c);
    load     <= 1'b1;
    load_val <= c;
    @(posedge mclk);
    load <= 1'b0;
    @(posedge mclk);
  endtask : setcnt

  task automatic edges(input int n);
    repeat (n) begin
      srcs[0] <= 1'b1;
      repeat (6) @(posedge mclk);
      srcs[0] <= 1'b0;
      repeat (6) @(posedge mclk);
    end
  endtask : edges

  task automatic cap_src(input int s);
    wr(`CCP_OFS_SRC, 32'(s));
    wr(`CCP_OFS_STATUS, 32'h1);
    srcs[s] <= 1'b1;
    repeat (8) @(posedge mclk);
    rd(`CCP_OFS_VALUE, {16'h0, v}, 32'hffff);
    rd(`CCP_OFS_STATUS, 32'h1, 32'h1);
    srcs[s] <= 1'b0;
    repeat (8) @(posedge mclk);
  endtask : cap_src

  task automatic cmp_run(input logic [7:0] m);
    run <= 1'b0;
    wr(`CCP_OFS_CTRL, {24'h0, m});
    wr(`CCP_OFS_STATUS, 32'h1);
    setcnt(v - 16'h0006);
    run <= 1'b1;
  endtask : cmp_run

  // time limit on the whole run
  initial begin
    repeat (30000) @(posedge mclk);
    num_errors++;
    stop_test;
  end

  // main sequence
  initial begin
    repeat (10) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    rd(`CCP_OFS_CTRL, `CCP_CTRL_RST, 32'hff);
    rd(`CCP_OFS_PERIOD, `CCP_PERIOD_RST, 32'hff);
    rd(6'h3c, 32'h0, 32'hffffffff);
    v = 16'($random(seed));
    wr(`CCP_OFS_PERIOD, {24'h0, v[7:0]});
    rd(`CCP_OFS_PERIOD, {24'h0, v[7:0]}, 32'hff);
    $display("test registers done");
    v = 16'($random(seed));
    setcnt(v);
    wr(`CCP_OFS_CTRL, 32'h85);
    for (i = 0; i < 8; i++) cap_src(i);
    wr(`CCP_OFS_SRC, 32'h0);
    wr(`CCP_OFS_STATUS, 32'h1);
    port_write <= 1'b1;
    @(posedge mclk);
    port_write <= 1'b0;
    repeat (8) @(posedge mclk);
    rd(`CCP_OFS_STATUS, 32'h1, 32'h1);
    wr(`CCP_OFS_CTRL, 32'h0);
    wr(`CCP_OFS_CTRL, 32'h84);
    wr(`CCP_OFS_STATUS, 32'h1);
    srcs[0] <= 1'b1;
    repeat (8) @(posedge mclk);
    rd(`CCP_OFS_STATUS, 32'h0, 32'h1);
    srcs[0] <= 1'b0;
    repeat (8) @(posedge mclk);
    rd(`CCP_OFS_STATUS, 32'h1, 32'h1);
    $display("test capture done");
    wr(`CCP_OFS_CTRL, 32'h0);
    wr(`CCP_OFS_CTRL, 32'h86);
    wr(`CCP_OFS_STATUS, 32'h1);
    edges(3);
    rd(`CCP_OFS_STATUS, 32'h0, 32'h1);
    edges(1);
    rd(`CCP_OFS_STATUS, 32'h1, 32'h1);
    wr(`CCP_OFS_STATUS, 32'h1);
    edges(2);
    wr(`CCP_OFS_CTRL, 32'h0);
    wr(`CCP_OFS_CTRL, 32'h86);
    wr(`CCP_OFS_STATUS, 32'h1);
    edges(2);
    rd(`CCP_OFS_STATUS, 32'h0, 32'h1);
    wr(`CCP_OFS_CTRL, 32'h0);
    wr(`CCP_OFS_CTRL, 32'h87);
    wr(`CCP_OFS_STATUS, 32'h1);
    edges(15);
    rd(`CCP_OFS_STATUS, 32'h0, 32'h1);
    edges(1);
    rd(`CCP_OFS_STATUS, 32'h1, 32'h1);
    $display("test prescaler done");
    v = 16'h0100 + (16'($random(seed)) & 16'h0fff);
    wr(`CCP_OFS_VALUE, {16'h0, v});
    cmp_run(8'h88);
    wait_out(0, 1'b1, 100);
    chk(32'(g), 32'h1);
    rd(`CCP_OFS_STATUS, 32'h1, 32'h1);
    cmp_run(8'h89);
    wait_out(0, 1'b0, 100);
    chk(32'(g), 32'h0);
    cmp_run(8'h82);
    wait_out(0, 1'b1, 100);
    chk(32'(g), 32'h1);
    repeat (8) @(posedge mclk);
    chk(32'(pin_out), 32'h1);
    chk(32'(module_out), 32'h1);
    wr(`CCP_OFS_CTRL, 32'h0);
    wait_out(0, 1'b0, 4);
    chk(32'(g), 32'h0);
    wr(`CCP_OFS_ADCSEL, 32'h1);
    cmp_run(8'h8a);
    wait_out(1, 1'b1, 100);
    chk(32'(g), 32'h1);
    cmp_run(8'h8b);
    wait_out(3, 1'b1, 100);
    chk(32'(g), 32'h1);
    wr(`CCP_OFS_ADCSEL, 32'h0);
    cmp_run(8'h8a);
    wait_out(1, 1'b1, 60);
    chk(32'(g), 32'h0);
    run <= 1'b0;
    wr(`CCP_OFS_IEN, 32'h1);
    wait_out(2, 1'b1, 10);
    chk(32'(g), 32'h1);
    wr(`CCP_OFS_IEN, 32'h0);
    wait_out(2, 1'b0, 10);
    chk(32'(g), 32'h0);
    $display("test compare done");
    for (i = 0; i < 2; i++) begin
      v = 16'h0001 + (16'($random(seed)) & 16'h001e);
      wr(`CCP_OFS_PWMCTL, 32'h0);
      wr(`CCP_OFS_CTRL, 32'h0);
      wr(`CCP_OFS_PERIOD, 32'h7);
      wr(`CCP_OFS_CTRL, 32'h8f | (32'(i) << 4));
      wr(`CCP_OFS_VALUE, {16'h0, i[0] ? {v[9:0], 6'h0} : v});
      wr(`CCP_OFS_STATUS, 32'h2);
      wr(`CCP_OFS_PWMCTL, 32'h4);
      wait_out(0, 1'b1, 100);
      hold(1'b1, nh);
      hold(1'b0, nl);
      chk(32'(nh), {16'h0, v});
      chk(32'(nl), 32'h20 - {16'h0, v});
      rd(`CCP_OFS_STATUS, 32'h2, 32'h2);
    end
    wr(`CCP_OFS_VALUE, 32'h0);
    wait_out(0, 1'b0, 40);
    wait_out(0, 1'b1, 70);
    chk(32'(g), 32'h0);
    $display("test pwm done");
    stop_test;
  end
endmodule : testbench
`default_nettype wire
